/* File: core/adc_out_pkg.sv */
// constants and types for the converter output and power-mode block
package adc_out_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] PLL_OFS  = 4'h8;
  // control register fields
  localparam int CTL_PD      = 0;
  localparam int CTL_STBY    = 1;
  localparam int CTL_LOWSW   = 2;
  localparam int CTL_BOOST   = 3;
  localparam int CTL_OFFBIN  = 4;
  localparam int CTL_ONELANE = 5;
  localparam int CTL_RES10   = 6;
  localparam int CTL_LSBF    = 7;
  localparam int CTL_PH_LSB  = 8;
  localparam logic [2:0] PHASE_RST = 3'h3;
  localparam logic [2:0] PHASE_MAX = 3'h5;
  // status register fields
  localparam int STS_PD     = 0;
  localparam int STS_STBY   = 1;
  localparam int STS_PIN    = 2;
  localparam int STS_OVF    = 3;
  localparam int STS_ACTIVE = 4;
  // sample format
  localparam int SAMPLE_W = 12;
  localparam logic [3:0] SLOTS_12 = 4'h6;
  localparam logic [3:0] SLOTS_10 = 4'h5;
  localparam logic [11:0] CODE_POS = 12'h7ff;
  localparam logic [11:0] CODE_MSB = 12'h800;
  // serial timing, in aclk cycles per data slot; must divide by three
  localparam int HALF_BIT_CYC = 6;
  localparam int FIFO_DEPTH   = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SHIFT} ser_state_type;
endpackage : adc_out_pkg

/* File: core/sample_fifo.sv */
// small fifo with registered read data between sampling and serializer
`timescale 1ns/10ps
module sample_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
    logic [W-1:0]            rd;
    logic                    rv;
  } fifo_st_type;
  fifo_st_type q, d;
  logic [AW:0] cnt;

  assign cnt       = q.wp - q.rp;
  assign in_ready  = (cnt != (AW+1)'(DEPTH));
  assign out_valid = q.rv;
  assign out_data  = q.rd;

  always_comb begin
    d = q;
    if (q.rv && out_ready) begin
      d.rv = 1'b0;
    end
    // refill the output register as soon as it is free
    if (!d.rv && cnt != '0) begin
      d.rd = q.mem[q.rp[AW-1:0]];
      d.rv = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (in_valid && in_ready) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (flush) begin
      d.wp = '0;
      d.rp = '0;
      d.rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  fifo_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid && !out_ready && !flush |=> out_valid && $stable(out_data))
    else $error("fifo output lost while stalled");
endmodule : sample_fifo

/* File: core/adc_serial_out.sv */
// serial output, coding and power-mode control of a dual 12-bit converter
`timescale 1ns/10ps
module adc_serial_out
  import adc_out_pkg::*;
#(
  parameter int HALF_BIT = adc_out_pkg::HALF_BIT_CYC,
  parameter int DEPTH    = adc_out_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // register bus
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // pins and converter core
  input  wire logic              power_down_pin,
  input  wire logic              sample_clk,
  input  wire logic signed [12:0] ch0_sample,
  input  wire logic signed [12:0] ch1_sample,
  output logic                   sample_ready,
  // serial link: lanes {ch1 b, ch1 a, ch0 b, ch0 a}
  output logic [3:0]             lane_out,
  output logic [3:0]             lane_oe,
  output logic                   bit_clock_out,
  output logic                   bit_clock_oe,
  output logic                   frame_clock_out,
  output logic                   frame_clock_oe,
  // analog controls
  output logic                   ref_power_on,
  output logic                   core_active,
  output logic                   low_swing,
  output logic                   drive_boost,
  output logic                   low_rate_pll
);
  import adc_out_pkg::*;

  typedef struct packed {
    logic pd_s1, pd_s2, sc_s1, sc_s2, sc_s3;
    logic pd_reg, stby, low_sw, boost, ob, one_lane, res10, lsbf;
    logic [2:0] phase;
    logic pll, ovf;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    ser_state_type state;
    logic [7:0] t, ph;
    logic [3:0] slot, nslots;
    logic wone;
    logic [11:0] sh0, sh1;
    logic [3:0] lane;
    logic oe, bclk, fclk, ref_on, active, samp_rdy;
  } st_type;

  st_type q, d;
  logic        pd_eff, push, pop, f_in_rdy, f_valid, wr_go, ctrl_wr;
  logic [23:0] f_in, f_out;
  logic [11:0] code0, code1;
  logic [8:0]  bc_pos;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [3:0] a);
    return (a == CTRL_OFS) || (a == STAT_OFS) || (a == PLL_OFS);
  endfunction : mapped

  // clamp then code
  function automatic logic [11:0] code_sample(input logic signed [12:0] v,
                                              input logic ob);
    logic [11:0] c;
    c = v[11:0];
    if (v > 13'sd2047) begin
      c = CODE_POS;
    end else if (v < -13'sd2048) begin
      c = CODE_MSB;
    end
    return ob ? (c ^ CODE_MSB) : c;
  endfunction : code_sample

  // s[i] is the i-th bit on the wire
  function automatic logic [11:0] order_word(input logic [11:0] w,
                                             input logic r10,
                                             input logic lsb);
    logic [11:0] s;
    s = '0;
    for (int i = 0; i < SAMPLE_W; i++) begin
      if (r10 && i < 10) begin
        s[i] = lsb ? w[i+2] : w[11-i];
      end else if (!r10) begin
        s[i] = lsb ? w[i] : w[11-i];
      end
    end
    return s;
  endfunction : order_word

  function automatic logic [31:0] read_word(input st_type s,
                                            input logic [3:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      CTRL_OFS: begin
        r[CTL_PD]      = s.pd_reg;
        r[CTL_STBY]    = s.stby;
        r[CTL_LOWSW]   = s.low_sw;
        r[CTL_BOOST]   = s.boost;
        r[CTL_OFFBIN]  = s.ob;
        r[CTL_ONELANE] = s.one_lane;
        r[CTL_RES10]   = s.res10;
        r[CTL_LSBF]    = s.lsbf;
        r[CTL_PH_LSB +: 3] = s.phase;
      end
      STAT_OFS: begin
        r[STS_PD]     = !s.oe;
        r[STS_STBY]   = s.oe && !s.active;
        r[STS_PIN]    = s.pd_s2;
        r[STS_OVF]    = s.ovf;
        r[STS_ACTIVE] = s.state == ST_SHIFT;
      end
      PLL_OFS: r[0] = s.pll;
      default: r = '0;
    endcase
    return r;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////
  assign code0 = code_sample(ch0_sample, q.ob);
  assign code1 = code_sample(ch1_sample, q.ob);
  assign f_in  = {order_word(code1, q.res10, q.lsbf),
                  order_word(code0, q.res10, q.lsbf)};
  // sample clock edge found on the synchronised copy only
  assign push  = q.sc_s2 && !q.sc_s3 && q.state != ST_OFF;

  sample_fifo #(.W(24), .DEPTH(DEPTH)) fifo_i (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (q.state == ST_OFF),
    .in_valid  (push),
    .in_data   (f_in),
    .in_ready  (f_in_rdy),
    .out_valid (f_valid),
    .out_data  (f_out),
    .out_ready (pop)
  );

  always_comb begin
    d = q;
    pop = 1'b0;
    ctrl_wr = 1'b0;
    d.pd_s1 = power_down_pin;
    d.pd_s2 = q.pd_s1;
    d.sc_s1 = sample_clk;
    d.sc_s2 = q.sc_s1;
    d.sc_s3 = q.sc_s2;
    // write channel: address and data in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    wr_go = d.aw_got && d.w_got;
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = mapped(d.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (d.awaddr == CTRL_OFS && d.wstrb[0]) begin
        ctrl_wr    = 1'b1;
        d.pd_reg   = d.wdata[CTL_PD];
        d.stby     = d.wdata[CTL_STBY];
        d.low_sw   = d.wdata[CTL_LOWSW];
        d.boost    = d.wdata[CTL_BOOST];
        d.ob       = d.wdata[CTL_OFFBIN];
        d.one_lane = d.wdata[CTL_ONELANE];
        d.res10    = d.wdata[CTL_RES10];
        d.lsbf     = d.wdata[CTL_LSBF];
      end
      // out-of-range phase codes are ignored
      if (d.awaddr == CTRL_OFS && d.wstrb[1] &&
          d.wdata[CTL_PH_LSB +: 3] <= PHASE_MAX) begin
        d.phase = d.wdata[CTL_PH_LSB +: 3];
      end
      if (d.awaddr == STAT_OFS && d.wstrb[0] && d.wdata[STS_OVF]) begin
        d.ovf = 1'b0;
      end
      if (d.awaddr == PLL_OFS && d.wstrb[0]) begin
        d.pll = d.wdata[0];
      end
    end
    // overflow set after the clear so a coincident event is kept
    if (push && !f_in_rdy) begin
      d.ovf = 1'b1;
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = read_word(q, s_axi_araddr);
      d.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    d.arready = !d.rvalid;

    pd_eff = d.pd_s2 || d.pd_reg;
    // slot timing runs from aclk; words pace off the fifo
    d.t  = (q.t == 8'(HALF_BIT-1)) ? '0 : q.t + 8'h01;
    d.ph = (q.ph == 8'(2*HALF_BIT-1)) ? '0 : q.ph + 8'h01;
    case (q.state)
      ST_OFF: begin
        d.t  = '0;
        d.ph = '0;
        d.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (q.t == 8'(HALF_BIT-1) && f_valid) begin
          pop = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (q.t == 8'(HALF_BIT-1)) begin
          if (q.slot == q.nslots - 4'h1) begin
            pop = f_valid;
            d.state = f_valid ? ST_SHIFT : ST_IDLE;
          end else begin
            d.slot = q.slot + 4'h1;
            d.sh0 = q.wone ? q.sh0 >> 1 : q.sh0 >> 2;
            d.sh1 = q.wone ? q.sh1 >> 1 : q.sh1 >> 2;
          end
        end
      end
      default: d.state = ST_OFF;
    endcase
    if (pop) begin
      d.state  = ST_SHIFT;
      d.slot   = '0;
      d.sh0    = f_out[11:0];
      d.sh1    = f_out[23:12];
      d.wone   = q.one_lane;
      d.nslots = q.res10 ? SLOTS_10 : SLOTS_12;
      if (q.one_lane) begin
        d.nslots = {d.nslots[2:0], 1'b0};
      end
    end
    if (pd_eff) begin
      d.state = ST_OFF;
    end

    // outputs, all registered
    d.lane = '0;
    if (d.state == ST_SHIFT) begin
      d.lane = {d.wone ? 1'b0 : d.sh1[1], d.sh1[0],
                d.wone ? 1'b0 : d.sh0[1], d.sh0[0]};
    end
    d.fclk = (d.state == ST_SHIFT) &&
             (d.slot < ((d.nslots + 4'h1) >> 1));
    // phase offset of a bit clock period is phase * 60 degrees
    // larger phase code delays the bit clock against the slot edges
    bc_pos = 9'(d.ph) + 9'(2*HALF_BIT) -
             9'(d.phase * 8'(HALF_BIT / 3));
    if (bc_pos >= 9'(2*HALF_BIT)) begin
      bc_pos = bc_pos - 9'(2*HALF_BIT);
    end
    d.bclk = (d.state != ST_OFF) && (bc_pos < 9'(HALF_BIT));
    d.oe       = !pd_eff;
    d.ref_on   = !pd_eff;
    d.active   = !pd_eff && !d.stby;
    d.samp_rdy = f_in_rdy && !pd_eff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.phase <= PHASE_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.state <= ST_OFF;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign sample_ready    = q.samp_rdy;
  assign lane_out        = q.lane;
  assign lane_oe         = {4{q.oe}};
  assign bit_clock_out   = q.bclk;
  assign bit_clock_oe    = q.oe;
  assign frame_clock_out = q.fclk;
  assign frame_clock_oe  = q.oe;
  assign ref_power_on    = q.ref_on;
  assign core_active     = q.active;
  assign low_swing       = q.low_sw;
  assign drive_boost     = q.boost;
  assign low_rate_pll    = q.pll;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pin_hiz_a: assert property (power_down_pin |-> ##2 lane_oe == 4'h0)
    else $error("drivers still on after pin power-down");
  reg_pd_a: assert property (q.pd_reg |-> !bit_clock_oe && !q.fclk)
    else $error("register power-down ignored");
  wake_a: assert property ($fell(q.pd_s2) && !q.pd_reg |-> lane_oe == 4'hf)
    else $error("no wake after pin release");
  standby_a: assert property (q.stby && q.oe |-> ref_power_on && !core_active)
    else $error("standby state wrong");
  drive_set_a: assert property (ctrl_wr |=> low_swing == $past(d.low_sw) &&
    drive_boost == $past(d.boost))
    else $error("drive setting not applied");
  code_sat_a: assert property (ch0_sample > 13'sd2047 |->
    code0 == (q.ob ? 12'hfff : CODE_POS))
    else $error("positive saturation code wrong");
  code_zero_a: assert property (ch0_sample == 13'sd0 |->
    code0 == (q.ob ? CODE_MSB : 12'h000))
    else $error("zero code wrong");
  frame_start_a: assert property (q.state == ST_SHIFT && q.slot == '0
    |-> frame_clock_out)
    else $error("frame clock missing at word start");
  bclk_half_a: assert property ($changed(bit_clock_out) && q.oe &&
    $past(q.oe, 2*HALF_BIT+2) && q.phase == $past(q.phase, HALF_BIT+1)
    |-> $past(bit_clock_out, HALF_BIT) != bit_clock_out &&
    $past(bit_clock_out, HALF_BIT+1) == bit_clock_out)
    else $error("bit clock half period wrong");
  one_lane_a: assert property (q.state == ST_SHIFT && q.wone |->
    lane_out[1] == 1'b0 && lane_out[3] == 1'b0)
    else $error("second lane active in one-lane mode");
  two_lane_a: assert property (q.state == ST_SHIFT && !q.wone |->
    lane_out[1] == q.sh0[1] && q.nslots <= SLOTS_12)
    else $error("lane split wrong");
  short_a: assert property (pop && q.res10 && !q.one_lane |=>
    q.nslots == SLOTS_10)
    else $error("short word length wrong");

  word_c: cover property (pop ##1 q.state == ST_SHIFT);
  short_c: cover property (pop && q.res10);
  one_c: cover property (pop && q.one_lane);
  pd_c: cover property ($fell(lane_oe[0]) ##[1:50] $rose(lane_oe[0]));
endmodule : adc_serial_out

/* File: verif/lvds_rx_model.sv */
// behavioural receiver that rebuilds sample words from the four lanes
`timescale 1ns/10ps
module lvds_rx_model #(
  parameter int HB = 3
) (
  // clock
  input  wire logic        aclk,
  // link
  input  wire logic [3:0]  lane,
  input  wire logic        fclk,
  // word format
  input  wire logic        one_lane,
  input  wire logic [3:0]  n_bits,
  // captured words
  output logic [11:0]      w0,
  output logic [11:0]      w1,
  output int               words
);
  logic        fclk_q = 1'b0;
  logic [11:0] b0     = 12'h0;
  logic [11:0] b1     = 12'h0;
  int          got    = 12;
  int          tmr    = 0;

  initial begin
    words = 0;
    w0 = 12'h0;
    w1 = 12'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // resync on every frame rise so a mode change costs one word at most
  always @(posedge aclk) begin
    fclk_q <= fclk;
    if (fclk && !fclk_q) begin
      got = 0;
      tmr = 0;
      b0 = 12'h0;
      b1 = 12'h0;
    end
    if (got < n_bits && tmr == 0) begin
      // one bit per bit clock edge on each lane in use
      if (one_lane) begin
        b0 = {b0[10:0], lane[0]};
        b1 = {b1[10:0], lane[2]};
        got += 1;
      end else begin
        b0 = {b0[9:0], lane[0], lane[1]};
        b1 = {b1[9:0], lane[2], lane[3]};
        got += 2;
      end
      tmr = HB - 1;
      if (got >= n_bits) begin
        w0 <= b0;
        w1 <= b1;
        words <= words + 1;
      end
    end else if (tmr > 0) begin
      tmr--;
    end
  end
endmodule : lvds_rx_model

/* File: verif/tb_adc_serial_out.sv */
// testbench for the converter serial output and power-mode block
`timescale 1ns/10ps
module tb_adc_serial_out;
  import adc_out_pkg::*;
  localparam int HB = 3;
  localparam int P  = 2 * HB * 4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, power_down_pin = 1'b0;
  logic        sample_clk = 1'b0;
  logic signed [12:0] ch0_sample = 13'h0, ch1_sample = 13'h0001;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, sample_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp, bresp;
  logic [31:0] s_axi_rdata, d;
  logic [3:0]  lane_out, lane_oe, lw, lw_q = 4'h0;
  logic        bit_clock_out, bit_clock_oe, frame_clock_out;
  logic        frame_clock_oe, ref_power_on, core_active;
  logic        low_swing, drive_boost, low_rate_pll;
  logic [7:0]  cur = 8'h0, c;
  logic [11:0] w0, w1;
  int          words, bad_count = 0, checked = 0;
  int          lb = 0, pb = 0, lf = 0, fh = 0, x0, v;
  int          vs[5] = '{-2048, 0, 2047, -3000, 3000};
  int          mv[4] = '{1, 2047, 'h123, 5};
  logic [7:0]  mc[4] = '{8'h80, 8'h40, 8'h20, 8'he0};

  always #2 aclk = ~aclk;
  always #62.5 sample_clk = ~sample_clk;
  // released lanes toggle so a stale level never looks like data
  assign lw = (lane_out & lane_oe) | (~lw_q & ~lane_oe);
  always @(posedge aclk) lw_q <= lw;
  always @(posedge bit_clock_out) begin
    pb = lb;
    lb = int'($time);
  end
  always @(posedge frame_clock_out) lf = int'($time);
  always @(negedge frame_clock_out) fh = int'($time) - lf;

  adc_serial_out #(.HALF_BIT(HB)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_down_pin, .sample_clk,
    .ch0_sample, .ch1_sample, .sample_ready, .lane_out, .lane_oe,
    .bit_clock_out, .bit_clock_oe, .frame_clock_out, .frame_clock_oe,
    .ref_power_on, .core_active, .low_swing, .drive_boost,
    .low_rate_pll);

  lvds_rx_model #(.HB(HB)) u_rx (
    .aclk, .lane(lw), .fclk(frame_clock_out), .one_lane(cur[5]),
    .n_bits(cur[6] ? 4'ha : 4'hc), .w0, .w1, .words);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] dd);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t >= 50) bad_count++;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] dd);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    dd = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 50) bad_count++;
  endtask : rd

  task automatic ww(input int n);
    int w, t;
    w = words;
    t = 0;
    while (words < w + n && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    if (t >= 3000) bad_count++;
  endtask : ww

  task automatic wo(input logic [3:0] e);
    int t;
    t = 0;
    while (lane_oe !== e && t < 20) begin
      @(posedge aclk);
      t++;
    end
  endtask : wo

  // expected word: saturate, code, shorten, order
  function automatic logic [11:0] ew(input int vv, input logic [7:0] cc);
    logic [11:0] e, r;
    int n;
    vv = vv < -2048 ? -2048 : (vv > 2047 ? 2047 : vv);
    e = vv[11:0] ^ (cc[4] ? 12'h800 : 12'h0);
    n = cc[6] ? 10 : 12;
    if (cc[6]) e = e >> 2;
    r = e;
    if (cc[7]) for (int i = 0; i < n; i++) r[i] = e[n-1-i];
    return r;
  endfunction : ew

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(CTRL_OFS, d);
    chk("ctrl reset", d, 32'h0000_0300);
    chk("swing boost", {low_swing, drive_boost}, 32'h0);
    chk("oe", {lane_oe, bit_clock_oe, frame_clock_oe}, 32'h3f);
    rd(4'hc, d);
    chk("unmapped", {rresp, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(CTRL_OFS, 32'h0000_030c);
    chk("swing boost", {low_swing, drive_boost}, 32'h3);
    wr(PLL_OFS, 32'h0000_0001);
    chk("pll", low_rate_pll, 32'h1);
    chk("bresp ok", bresp, RESP_OKAY);
    wr(4'hc, 32'h0000_0001);
    chk("bresp unmapped", bresp, RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      c = i < 10 ? (i >= 5 ? 8'h10 : 8'h00) : mc[i-10];
      v = i < 10 ? vs[i%5] : mv[i-10];
      cur = c;
      @(posedge aclk);
      ch0_sample <= 13'(v);
      wr(CTRL_OFS, {24'h3, c});
      // a full fifo plus output register still holds old-format words
      ww(14);
      chk("ch0 word", w0, ew(v, c));
      chk("ch1 word", w1, ew(1, c));
    end
    $display("test stream done");
    cur = 8'h0;
    wr(CTRL_OFS, 32'h0000_0300);
    ww(4);
    x0 = ((lb - lf) % P + P) % P;
    chk("bit period", lb - pb, P);
    chk("frame high", fh, 3 * HB * 4);
    wr(CTRL_OFS, 32'h0000_0400);
    ww(4);
    chk("phase step", (((lb - lf) % P + P) % P - x0 + P) % P, P / 6);
    wr(CTRL_OFS, 32'h0000_0600);
    rd(CTRL_OFS, d);
    chk("phase keep", d, 32'h0000_0400);
    $display("test clocks done");
    @(posedge aclk);
    power_down_pin <= 1'b1;
    wo(4'h0);
    chk("pin pd", {lane_oe, bit_clock_oe, frame_clock_oe,
                   ref_power_on, core_active, sample_ready}, 32'h0);
    wr(CTRL_OFS, 32'h0000_0302);
    rd(STAT_OFS, d);
    chk("status", d & 32'h7, 32'h5);
    @(posedge aclk);
    power_down_pin <= 1'b0;
    wo(4'hf);
    chk("standby", {lane_oe, ref_power_on, core_active}, 32'h3e);
    wr(CTRL_OFS, 32'h0000_0301);
    wo(4'h0);
    chk("reg pd", {lane_oe, bit_clock_oe, ref_power_on}, 32'h0);
    wr(CTRL_OFS, 32'h0000_0300);
    wo(4'hf);
    chk("wake", {lane_oe, ref_power_on, core_active}, 32'h3f);
    $display("test power done");
    report_and_stop;
  end
endmodule : tb_adc_serial_out
